// ===== core/gochp_pkg.sv
// Package of constants for the optional command handler
package gochp_pkg;
    localparam logic [7:0] OPC_ACCESS     = 8'hC6;
    localparam logic [7:0] OPC_BLK_WRITE  = 8'hC7;
    localparam logic [7:0] OPC_BLK_PLOCK  = 8'hC9;
    localparam logic [7:0] ERR_CODE_OTHER = 8'h00;
    localparam logic [1:0] BANK_USER      = 2'h3;
    // Variant selectors
    localparam logic [1:0] VAR_U512 = 2'h0;
    localparam logic [1:0] VAR_U128 = 2'h1;
    localparam logic [1:0] VAR_U32  = 2'h2;
    localparam logic [1:0] VAR_U480 = 2'h3;
    localparam logic [9:0] USER_BITS_512 = 10'h200;
    localparam logic [9:0] USER_BITS_480 = 10'h1E0;
    localparam logic [9:0] USER_BITS_128 = 10'h080;
    localparam logic [9:0] USER_BITS_32  = 10'h020;
    localparam logic [9:0] EPC_BITS_U512 = 10'h080;
    localparam logic [9:0] EPC_BITS_U128 = 10'h1F0;
    localparam logic [9:0] EPC_BITS_U32  = 10'h080;
    localparam logic [9:0] EPC_BITS_U480 = 10'h100;
    localparam int         BLOCK_BITS    = 128;
    localparam int         NUM_BLOCKS    = 4;
    localparam int         RSV_WORDS     = 4;
    localparam int         TID_WORDS     = 6;
    // Arbitrary neutral identity values
    localparam logic [15:0] TID_WORD0    = 16'hE200;
    localparam logic [15:0] TID_WORD1    = 16'h0000;
    localparam logic [15:0] TID_XHDR     = 16'h0000;
    localparam logic [47:0] TID_SERIAL   = 48'h000000000001;
    // Reply turnaround delay in ns and cycles at 100 MHz
    localparam int          CLK_NS       = 10;
    localparam int          T1_NS        = 20000;
    localparam logic [11:0] T1_CYC       = 12'((T1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'h1021;
    localparam logic [5:0]  ERR_FRAME_LEN = 6'h29; // header+code+handle+crc = 41
    localparam logic [7:0]  PERMALOCK_NONE = 8'h00;
    localparam logic [1:0]  ENC_FM0      = 2'h0;
endpackage

// ===== core/gochp_rx_if.sv
// Interface carrying the combined forward-link bit stream
`timescale 1ns/1ps
interface gochp_rx_if;
    logic bit_valid;
    logic bit_val;
    logic frame_start;
    modport src (output bit_valid, output bit_val, output frame_start);
    modport dst (input bit_valid, input bit_val, input frame_start);
endinterface

// ===== core/gochp_pie_rx.sv
// PIE symbol decoder combining both antenna demodulator outputs
`timescale 1ns/1ps
module gochp_pie_rx
    import gochp_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Demodulated envelopes, high = carrier present
    input  wire logic env_a,
    input  wire logic env_b,
    // Decoded stream
    gochp_rx_if.src   rx
);
    typedef struct packed {
        logic        env_q;
        logic [11:0] cnt;
        logic [11:0] tari;
        logic        have_tari;
        logic        bit_valid;
        logic        bit_val;
        logic        frame_start;
    } gochp_pie_st_t;

    gochp_pie_st_t st_ff, nxt_st;
    logic          env;
    logic [12:0]   one_thr;

    // Data-1 threshold at 1.25 reference; one bit wider so a long reference cannot wrap
    assign one_thr = {1'b0, st_ff.tari} + {3'h0, st_ff.tari[11:2]};

    // Either port seeing a low pulse counts; envelope detection is modulation-agnostic
    assign env = env_a & env_b;

    // Measure high time between low pulses; first interval sets reference
    always_comb begin
        nxt_st             = st_ff;
        nxt_st.bit_valid   = 1'b0;
        nxt_st.frame_start = 1'b0;
        nxt_st.env_q       = env;
        if (env) begin
            nxt_st.cnt = (st_ff.cnt == 12'hFFF) ? st_ff.cnt : st_ff.cnt + 12'h001;
        end
        if (!env && st_ff.env_q) begin
            nxt_st.cnt = 12'h000;
            if (st_ff.cnt == 12'hFFF) begin
                nxt_st.have_tari   = 1'b0; // Long gap starts a new frame
                nxt_st.frame_start = 1'b1;
            end else if (!st_ff.have_tari) begin
                nxt_st.tari      = st_ff.cnt;
                nxt_st.have_tari = 1'b1;
            end else begin
                nxt_st.bit_valid = 1'b1; // Data-1 is longer than 1.25 data-0
                nxt_st.bit_val   = ({1'b0, st_ff.cnt} > one_thr);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rx.bit_valid   = st_ff.bit_valid;
    assign rx.bit_val     = st_ff.bit_val;
    assign rx.frame_start = st_ff.frame_start;
endmodule // gochp_pie_rx

// ===== core/gochp_top.sv
// Optional command handler: decode, BlockWrite checks, BlockPermalock, error replies
`timescale 1ns/1ps
module gochp_top
    import gochp_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Configuration
    input  wire logic [1:0]  variant_sel,
    input  wire logic        public_profile,
    input  wire logic [15:0] handle,
    input  wire logic [1:0]  reply_enc_cmd,
    // Demodulator envelopes from the two ports
    input  wire logic        env_a,
    input  wire logic        env_b,
    // End of command frame marker
    input  wire logic        frame_end,
    // Decoded command
    output logic             cmd_access_ff,
    output logic             cmd_bwrite_ff,
    output logic             cmd_plock_ff,
    // NVM write request
    output logic             nvm_we_ff,
    output logic [1:0]       nvm_bank_ff,
    output logic [7:0]       nvm_wptr_ff,
    output logic [31:0]      nvm_wdata_ff,
    output logic [1:0]       nvm_nwords_ff,
    // Permalock state of user blocks
    output logic [3:0]       blk_lock_ff,
    // Reply bit stream
    output logic             reply_bit_ff,
    output logic             reply_valid_ff,
    output logic [1:0]       reply_enc_ff,
    output logic             reply_err_ff
);
    typedef enum logic [2:0] {S_IDLE, S_RECV, S_EXEC, S_WAIT, S_SEND} gochp_state_t;

    typedef struct packed {
        gochp_state_t state;
        logic [127:0] sreg;
        logic [7:0]   nbits;
        logic [11:0]  tcnt;
        logic [40:0]  frame;
        logic [5:0]   left;
        logic [15:0]  crc;
        logic         cmd_access;
        logic         cmd_bwrite;
        logic         cmd_plock;
        logic         nvm_we;
        logic [1:0]   nvm_bank;
        logic [7:0]   nvm_wptr;
        logic [31:0]  nvm_wdata;
        logic [1:0]   nvm_nwords;
        logic [3:0]   blk_lock;
        logic         reply_bit;
        logic         reply_valid;
        logic [1:0]   reply_enc;
        logic         reply_err;
    } gochp_top_st_t;

    gochp_top_st_t st_ff, nxt_st;
    gochp_rx_if    rx_bus ();

    // Antenna combining and PIE decoding
    gochp_pie_rx u_pie (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .env_a   (env_a),
        .env_b   (env_b),
        .rx      (rx_bus.src)
    );

    // Permalock is available only for the 480-bit variant and, without the public profile, the 512-bit one
    function automatic logic plock_ok(input logic [1:0] v, input logic pub);
        plock_ok = (v == VAR_U480) || ((v == VAR_U512) && !pub);
    endfunction

    // Top block is short in the 480-bit variant; no pointer is checked against this size
    function automatic logic [9:0] user_size(input logic [1:0] v);
        case (v)
            VAR_U512: user_size = USER_BITS_512;
            VAR_U480: user_size = USER_BITS_480;
            VAR_U128: user_size = USER_BITS_128;
            default:  user_size = USER_BITS_32;
        endcase
    endfunction

    // CRC-16 step over one bit
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
    endfunction

    logic [7:0]  opc;
    logic [1:0]  bank;
    logic [7:0]  wptr;
    logic [7:0]  wcnt;
    logic [31:0] wdata;
    logic [7:0]  plock_ptr;
    logic [7:0]  plock_mask;

    // Field extraction: opcode arrives first; EBV pointers assumed single byte
    always_comb begin
        opc        = st_ff.sreg[st_ff.nbits - 8'd1 -: 8];
        bank       = st_ff.sreg[st_ff.nbits - 8'd9 -: 2];
        wptr       = st_ff.sreg[st_ff.nbits - 8'd11 -: 8];
        wcnt       = st_ff.sreg[st_ff.nbits - 8'd19 -: 8];
        wdata      = st_ff.sreg[st_ff.nbits - 8'd27 -: 32];
        plock_ptr  = st_ff.sreg[st_ff.nbits - 8'd12 -: 8];
        plock_mask = st_ff.sreg[st_ff.nbits - 8'd28 -: 8];
    end

    // Command sequencer
    always_comb begin
        nxt_st             = st_ff;
        nxt_st.nvm_we      = 1'b0;
        nxt_st.cmd_access  = 1'b0;
        nxt_st.cmd_bwrite  = 1'b0;
        nxt_st.cmd_plock   = 1'b0;
        nxt_st.reply_enc   = reply_enc_cmd;
        case (st_ff.state)
            S_IDLE: begin
                nxt_st.reply_valid = 1'b0;
                nxt_st.reply_err   = 1'b0;
                if (rx_bus.frame_start) begin
                    nxt_st.nbits = 8'h00;
                    nxt_st.sreg  = '0;
                    nxt_st.state = S_RECV;
                end
            end
            S_RECV: begin
                if (rx_bus.bit_valid && st_ff.nbits != 8'hFF) begin
                    nxt_st.sreg  = {st_ff.sreg[126:0], rx_bus.bit_val};
                    nxt_st.nbits = st_ff.nbits + 8'h01;
                end
                if (frame_end) begin
                    nxt_st.state = S_EXEC;
                end
            end
            S_EXEC: begin
                nxt_st.state = S_IDLE;
                if (st_ff.nbits >= 8'h08) begin
                    // Frame lengths checked: exactly 56 bits for Access, more than 57 for BlockWrite, more than 66 for BlockPermalock
                    if (opc == OPC_ACCESS && st_ff.nbits == 8'd56) begin
                        nxt_st.cmd_access = 1'b1;
                    end else if (opc == OPC_BLK_WRITE && st_ff.nbits > 8'd57) begin
                        nxt_st.cmd_bwrite = 1'b1;
                        if (wcnt == 8'h00) begin
                            nxt_st.state = S_IDLE;
                        end else if (wcnt == 8'h01 || (wcnt == 8'h02 && !wptr[0])) begin
                            nxt_st.nvm_we     = 1'b1;
                            nxt_st.nvm_bank   = bank;
                            nxt_st.nvm_wptr   = wptr;
                            nxt_st.nvm_wdata  = wdata;
                            nxt_st.nvm_nwords = wcnt[1:0];
                        end else begin
                            // Odd pointer or too many words: nothing written
                            nxt_st.frame = {1'b1, ERR_CODE_OTHER, handle, 16'h0000};
                            nxt_st.crc   = CRC_INIT;
                            nxt_st.left  = ERR_FRAME_LEN;
                            nxt_st.tcnt  = T1_CYC;
                            nxt_st.state = S_WAIT;
                        end
                    end else if (opc == OPC_BLK_PLOCK && st_ff.nbits > 8'd66) begin
                        if (plock_ok(variant_sel, public_profile) && bank == BANK_USER) begin
                            nxt_st.cmd_plock = 1'b1;
                            if (plock_ptr == 8'h00) begin
                                // Mask MSB selects block 0 in the first 16-block word, the only one applied
                                nxt_st.blk_lock = st_ff.blk_lock
                                    | {plock_mask[4], plock_mask[5],
                                       plock_mask[6], plock_mask[7]};
                            end
                        end
                        // Otherwise silently ignored
                    end
                end
            end
            S_WAIT: begin
                // Reply turnaround before the error frame
                nxt_st.tcnt = st_ff.tcnt - 12'h001;
                if (st_ff.tcnt == 12'h001) begin
                    nxt_st.state = S_SEND;
                end
            end
            S_SEND: begin
                // Shift out header, code, handle, then the CRC computed on the fly
                nxt_st.reply_valid = 1'b1;
                nxt_st.reply_err   = 1'b1;
                nxt_st.reply_bit   = (st_ff.left > 6'd16) ? st_ff.frame[40] : ~st_ff.crc[15];
                if (st_ff.left > 6'd16) begin
                    nxt_st.crc = crc_step(st_ff.crc, st_ff.frame[40]);
                end else begin
                    nxt_st.crc = {st_ff.crc[14:0], 1'b1};
                end
                nxt_st.frame = {st_ff.frame[39:0], 1'b0};
                nxt_st.left  = st_ff.left - 6'd1;
                if (st_ff.left == 6'd1) begin
                    nxt_st.state = S_IDLE;
                end
            end
            default: nxt_st.state = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff       <= '0;
            st_ff.state <= S_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register
    assign cmd_access_ff  = st_ff.cmd_access;
    assign cmd_bwrite_ff  = st_ff.cmd_bwrite;
    assign cmd_plock_ff   = st_ff.cmd_plock;
    assign nvm_we_ff      = st_ff.nvm_we;
    assign nvm_bank_ff    = st_ff.nvm_bank;
    assign nvm_wptr_ff    = st_ff.nvm_wptr;
    assign nvm_wdata_ff   = st_ff.nvm_wdata;
    assign nvm_nwords_ff  = st_ff.nvm_nwords;
    assign blk_lock_ff    = st_ff.blk_lock;
    assign reply_bit_ff   = st_ff.reply_bit;
    assign reply_valid_ff = st_ff.reply_valid;
    assign reply_enc_ff   = st_ff.reply_enc;
    assign reply_err_ff   = st_ff.reply_err;
endmodule // gochp_top

// ===== tb/gochp_top_asserts.sv
// Concurrent checks on the optional command handler ports
`timescale 1ns/1ps
module gochp_top_asserts
    import gochp_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // Configuration
    input wire logic [1:0]  variant_sel,
    input wire logic        public_profile,
    input wire logic [1:0]  reply_enc_cmd,
    // Observed outputs
    input wire logic        cmd_access_ff,
    input wire logic        cmd_bwrite_ff,
    input wire logic        cmd_plock_ff,
    input wire logic        nvm_we_ff,
    input wire logic [1:0]  nvm_bank_ff,
    input wire logic [7:0]  nvm_wptr_ff,
    input wire logic [1:0]  nvm_nwords_ff,
    input wire logic [3:0]  blk_lock_ff,
    input wire logic        reply_valid_ff,
    input wire logic [1:0]  reply_enc_ff,
    input wire logic        reply_err_ff
);
    logic [11:0] gap_ff;
    logic [11:0] nxt_gap;
    logic        plock_ok;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Cycles since the last BlockWrite decode, saturating so it never wraps
    always_comb begin
        nxt_gap = cmd_bwrite_ff ? 12'h000 : ((gap_ff == 12'hFFF) ? gap_ff : gap_ff + 12'h001);
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_ff <= 12'h000;
        end else begin
            gap_ff <= nxt_gap;
        end
    end
    assign plock_ok = (variant_sel == VAR_U480) || (variant_sel == VAR_U512 && !public_profile);

    a_cmd_exclusive: assert property ($onehot0({cmd_access_ff, cmd_bwrite_ff, cmd_plock_ff}))
        else $error("two command decodes at once");
    a_bwrite_pulse: assert property (cmd_bwrite_ff |=> !cmd_bwrite_ff)
        else $error("BlockWrite decode longer than one cycle");
    a_write_legal: assert property (nvm_we_ff |-> nvm_bank_ff == BANK_USER &&
        (nvm_nwords_ff == 2'h1 || (nvm_nwords_ff == 2'h2 && !nvm_wptr_ff[0])))
        else $error("illegal block write reached memory");
    a_err_nowrite: assert property (reply_valid_ff |-> reply_err_ff && !nvm_we_ff)
        else $error("write during error reply");
    a_plock_ignored: assert property (cmd_plock_ff |-> plock_ok)
        else $error("permalock decoded on unsupported variant");
    a_lock_variant: assert property ($changed(blk_lock_ff) |-> plock_ok)
        else $error("lock bits changed on unsupported variant");
    a_lock_sticky: assert property ((~blk_lock_ff & $past(blk_lock_ff)) == 4'h0)
        else $error("lock bit cleared");
    a_reply_delay: assert property ($rose(reply_valid_ff) |-> gap_ff >= 12'h7C6)
        else $error("error reply started too early");
    // The register is cleared by reset, so the first edge after release is not judged
    a_enc_follow: assert property ($stable(reply_enc_cmd) && $past(resetn)
        |-> reply_enc_ff == reply_enc_cmd)
        else $error("reply encoding not as commanded");
endmodule // gochp_top_asserts

bind gochp_top gochp_top_asserts u_gochp_top_asserts (
    .sys_clk, .resetn, .variant_sel, .public_profile, .reply_enc_cmd,
    .cmd_access_ff, .cmd_bwrite_ff, .cmd_plock_ff, .nvm_we_ff, .nvm_bank_ff,
    .nvm_wptr_ff, .nvm_nwords_ff, .blk_lock_ff, .reply_valid_ff, .reply_enc_ff,
    .reply_err_ff
);

// ===== tb/gochp_reader_model.sv
// Reader model sending PIE command frames on one of two antenna envelopes
`timescale 1ns/1ps
module gochp_reader_model (
    // Clock
    input  wire logic sys_clk,
    // Envelopes and frame marker
    output logic      env_a,
    output logic      env_b,
    output logic      frame_end
);
    // Carrier present on both ports while idle
    initial begin
        env_a = 1'b1;
        env_b = 1'b1;
        frame_end = 1'b0;
    end

    // One symbol: carrier for hi cycles, then a 4-cycle pulse on the chosen port
    task automatic sym(input int hi, input logic use_b);
        env_a <= 1'b1;
        env_b <= 1'b1;
        repeat (hi) @(negedge sys_clk);
        if (use_b) begin
            env_b <= 1'b0;
        end else begin
            env_a <= 1'b0;
        end
        repeat (4) @(negedge sys_clk);
    endtask

    // Long carrier marks frame start; data-1 is 28 cycles, 1.75x the 16-cycle data-0
    task automatic send(input logic [127:0] v, input int n, input logic use_b);
        sym(4100, use_b);
        sym(12, use_b);
        for (int i = n - 1; i >= 0; i--) begin
            sym(v[i] ? 24 : 12, use_b);
        end
        env_a <= 1'b1;
        env_b <= 1'b1;
        @(negedge sys_clk);
        frame_end <= 1'b1;
        @(negedge sys_clk);
        frame_end <= 1'b0;
    endtask
endmodule // gochp_reader_model

// ===== tb/gochp_tb_top.sv
// Self-checking testbench for the optional command handler
`timescale 1ns/1ps
module gochp_tb_top
    import gochp_pkg::*;
;
    logic        sys_clk, resetn, public_profile, env_a, env_b, frame_end;
    logic [1:0]  variant_sel, reply_enc_cmd, nvm_bank_ff, nvm_nwords_ff, reply_enc_ff;
    logic [15:0] handle;
    logic        cmd_access_ff, cmd_bwrite_ff, cmd_plock_ff, nvm_we_ff;
    logic        reply_bit_ff, reply_valid_ff, reply_err_ff;
    logic [7:0]  nvm_wptr_ff;
    logic [31:0] nvm_wdata_ff;
    logic [3:0]  blk_lock_ff;
    logic [40:0] rep_bits;
    int          n_mismatch, checks_done, n_acc, n_bw, n_pl, n_we, n_rep;

    gochp_top u_gochp_top (.sys_clk, .resetn, .variant_sel, .public_profile, .handle,
        .reply_enc_cmd, .env_a, .env_b, .frame_end, .cmd_access_ff, .cmd_bwrite_ff,
        .cmd_plock_ff, .nvm_we_ff, .nvm_bank_ff, .nvm_wptr_ff, .nvm_wdata_ff,
        .nvm_nwords_ff, .blk_lock_ff, .reply_bit_ff, .reply_valid_ff, .reply_enc_ff,
        .reply_err_ff);
    gochp_reader_model u_gochp_reader_model (.sys_clk, .env_a, .env_b, .frame_end);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Event counters and reply capture, MSB arrives first
    always @(posedge sys_clk) begin
        n_acc += (cmd_access_ff === 1'b1);
        n_bw += (cmd_bwrite_ff === 1'b1);
        n_pl += (cmd_plock_ff === 1'b1);
        n_we += (nvm_we_ff === 1'b1);
        if (reply_valid_ff === 1'b1) begin
            n_rep++;
            rep_bits = {rep_bits[39:0], reply_bit_ff};
        end
    end

    task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Inverted CRC-16 over header bit, error code and handle
    function automatic logic [15:0] crc16(input logic [24:0] d);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 24; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        end
        return ~c;
    endfunction

    task automatic do_reset(input int cyc);
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (cyc) @(negedge sys_clk);
        resetn = 1'b1;
    endtask

    // Sends one frame, then waits w cycles; the BlockWrite tests pass 2100, past the reply turnaround, so a stray reply is seen
    task automatic run(input logic [127:0] v, input int n, input logic use_b, input int w);
        @(negedge sys_clk);
        {n_acc, n_bw, n_pl, n_we, n_rep} = '0;
        u_gochp_reader_model.send(v, n, use_b);
        repeat (w) @(negedge sys_clk);
    endtask

    task automatic t_bw_ok(input logic [7:0] ptr, input logic [7:0] cnt, input logic use_b);
        run(128'({OPC_BLK_WRITE, 2'h3, ptr, cnt, 32'hC3A5_5A3C}), 58, use_b, 2100);
        chk_cnt("bw_decode", 1, n_bw);
        chk_cnt("nvm_writes", 1, n_we);
        chk_val("nvm_bank", 64'(BANK_USER), 64'(nvm_bank_ff));
        chk_val("nvm_wptr", 64'(ptr), 64'(nvm_wptr_ff));
        chk_val("nvm_nwords", 64'(cnt[1:0]), 64'(nvm_nwords_ff));
        chk_val("nvm_wdata", 64'h0000_0000_C3A5_5A3C, 64'(nvm_wdata_ff));
        chk_cnt("no_reply", 0, n_rep);
    endtask

    task automatic t_bw_err(input logic [7:0] ptr, input logic [7:0] cnt);
        logic [24:0] hd;
        hd = {1'b1, ERR_CODE_OTHER, handle};
        run(128'({OPC_BLK_WRITE, 2'h3, ptr, cnt, 32'h1234_5678}), 58, 1'b0, 2100);
        chk_cnt("err_nowrite", 0, n_we);
        chk_cnt("err_len", 41, n_rep);
        chk_val("err_frame", 64'({hd, crc16(hd)}), 64'(rep_bits));
        chk_val("reply_enc", 64'h2, 64'(reply_enc_ff));
    endtask

    task automatic t_bw_zero;
        run(128'({OPC_BLK_WRITE, 2'h3, 8'h04, 8'h00, 32'hFFFF_0000}), 58, 1'b0, 2100);
        chk_cnt("zero_decode", 1, n_bw);
        chk_cnt("zero_write", 0, n_we);
        chk_cnt("zero_reply", 0, n_rep);
    endtask

    task automatic t_access;
        run(128'({OPC_ACCESS, 48'h5A5A_0F0F_A5A5}), 56, 1'b1, 20);
        chk_cnt("acc_decode", 1, n_acc);
        chk_cnt("acc_other", 0, n_bw + n_pl);
    endtask

    task automatic t_plock(input logic [1:0] vs, input logic pub, input logic [15:0] msk,
                           input logic [3:0] lk, input int nc);
        @(negedge sys_clk);
        variant_sel = vs;
        public_profile = pub;
        // Bank at bits 8-9, pointer from bit 11, range, mask from bit 27 (MSB = block 0)
        run(128'({OPC_BLK_PLOCK, 2'h3, 1'b0, 8'h00, 8'h01, msk, 24'h0}), 67, 1'b0, 10);
        chk_cnt("plock_decode", nc, n_pl);
        chk_val("blk_lock", 64'(lk), 64'(blk_lock_ff));
    endtask

    task automatic final_report;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs roughly 69k cycles
    initial begin
        repeat (95000) @(posedge sys_clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        {n_mismatch, checks_done, n_acc, n_bw, n_pl, n_we, n_rep} = '0;
        rep_bits = '0;
        resetn = 1'b0;
        variant_sel = VAR_U512;
        public_profile = 1'b0;
        handle = 16'hA5C3;
        reply_enc_cmd = ENC_FM0;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        reply_enc_cmd = 2'h2;
        t_access();
        t_bw_ok(8'h05, 8'h01, 1'b0);
        t_bw_ok(8'h04, 8'h02, 1'b1);
        t_bw_err(8'h07, 8'h02);
        t_bw_err(8'h04, 8'h03);
        t_bw_zero();
        t_plock(VAR_U128, 1'b0, 16'hF000, 4'h0, 0);
        t_plock(VAR_U32, 1'b0, 16'hF000, 4'h0, 0);
        t_plock(VAR_U512, 1'b1, 16'hF000, 4'h0, 0);
        t_plock(VAR_U480, 1'b0, 16'h9000, 4'h9, 1);
        do_reset(3);
        t_plock(VAR_U512, 1'b0, 16'h6000, 4'h6, 1);
        final_report();
    end
endmodule // gochp_tb_top
